/* File: src/trip_unit_setpoint_registers.sv */
// Setpoint register bank of the trip unit, reached by holding-register
// word requests from the serial link front end.
// Assumes the front end has already parsed frames into single-word requests.
`timescale 1ns/1ns
module trip_unit_setpoint_registers (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Variant strap and dial codes of the fixed-setting variant.
  input wire logic fixed_variant,
  input wire logic [15:0] dial_pickup_code,
  input wire logic [15:0] dial_delay_code,
  // Ground-fault function mode from the protection settings.
  input wire logic [1:0] gf_mode,
  // Word request.
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [19:0] req_addr,
  input wire logic [15:0] req_wdata,
  // Word answer.
  output logic rsp_valid,
  output logic [1:0] rsp_status,
  output logic [15:0] rsp_rdata,
  // Setpoints towards protection and the serial link.
  output logic [15:0] ground_fault_pickup_reg,
  output logic [15:0] ground_fault_delay_reg,
  output logic thermal_memory_en_reg,
  output logic [15:0] neutral_phase_ratio_reg,
  output logic [15:0] second_load_alarm_reg,
  output logic [15:0] ground_fault_warning_level_reg,
  output logic [15:0] link_slave_address_reg,
  output logic [1:0] link_baud_select_reg,
  output logic [1:0] link_parity_select_reg,
  output logic link_stop_bits_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Internal state.
  logic fixed_reg;
  logic [15:0] password_reg;
  logic [15:0] group_reg;
  logic [15:0] prealarm_setting_reg;
  logic [3:0] sel;
  logic link_page;
  logic writable;
  logic value_ok;
  logic dial_pickup_ok;
  logic dial_delay_ok;
  logic wr_ok;
  logic [15:0] rdata_next;
  logic [1:0] status_next;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode. The link page is only visible while the selector holds
  // the group code, so a stray access cannot retune the link by accident.
  assign link_page = group_reg == trip_setpoint_pkg::GROUP_LINK_CODE;

  always_comb begin
    sel = trip_setpoint_pkg::SEL_NONE;
    case (req_addr)
      trip_setpoint_pkg::ACCESS_PASSWORD_OFS: begin
        sel = trip_setpoint_pkg::SEL_PASSWORD;
      end
      trip_setpoint_pkg::SETTINGS_GROUP_SELECTOR_OFS: begin
        sel = trip_setpoint_pkg::SEL_GROUP;
      end
      trip_setpoint_pkg::LINK_SLAVE_ADDRESS_OFS: begin
        if (link_page) sel = trip_setpoint_pkg::SEL_SLAVE;
      end
      trip_setpoint_pkg::LINK_BAUD_SELECT_OFS: begin
        if (link_page) sel = trip_setpoint_pkg::SEL_BAUD;
      end
      trip_setpoint_pkg::LINK_PARITY_SELECT_OFS: begin
        if (link_page) sel = trip_setpoint_pkg::SEL_PARITY;
      end
      trip_setpoint_pkg::LINK_STOP_BITS_OFS: begin
        if (link_page) sel = trip_setpoint_pkg::SEL_STOP;
      end
      trip_setpoint_pkg::GROUND_FAULT_PICKUP_OFS: begin
        sel = trip_setpoint_pkg::SEL_PICKUP;
      end
      trip_setpoint_pkg::GROUND_FAULT_DELAY_OFS: begin
        sel = trip_setpoint_pkg::SEL_DELAY;
      end
      trip_setpoint_pkg::GROUND_FAULT_THERMAL_MEMORY_OFS: begin
        sel = trip_setpoint_pkg::SEL_THERMAL;
      end
      trip_setpoint_pkg::NEUTRAL_PROTECTION_RATIO_OFS: begin
        sel = trip_setpoint_pkg::SEL_NEUTRAL;
      end
      trip_setpoint_pkg::SECOND_LOAD_ALARM_LEVEL_OFS: begin
        if (!fixed_reg) sel = trip_setpoint_pkg::SEL_ALARM2;
      end
      trip_setpoint_pkg::GROUND_FAULT_PREALARM_OFS: begin
        sel = trip_setpoint_pkg::SEL_PREALARM;
      end
      default: sel = trip_setpoint_pkg::SEL_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code checks: one for the written word, one per dial.
  setpoint_code_check u_check_write (
    .sel(sel),
    .code(req_wdata),
    .fixed(fixed_reg),
    .ok(value_ok)
  );

  setpoint_code_check u_check_dial_pickup (
    .sel(trip_setpoint_pkg::SEL_PICKUP),
    .code(dial_pickup_code),
    .fixed(1'b1),
    .ok(dial_pickup_ok)
  );

  setpoint_code_check u_check_dial_delay (
    .sel(trip_setpoint_pkg::SEL_DELAY),
    .code(dial_delay_code),
    .fixed(1'b1),
    .ok(dial_delay_ok)
  );

  // The fixed variant sets pickup and delay by dial, never by the link.
  assign writable = !(fixed_reg &&
                      (sel == trip_setpoint_pkg::SEL_PICKUP ||
                       sel == trip_setpoint_pkg::SEL_DELAY));
  assign wr_ok = req_valid && req_write && sel != trip_setpoint_pkg::SEL_NONE
                 && writable && value_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Variant strap, caught while reset is held.
  always_ff @(posedge mclk) begin
    if (!rst_n) fixed_reg <= fixed_variant;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Communication group registers.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      password_reg <= trip_setpoint_pkg::PASSWORD_RESET;
      group_reg <= trip_setpoint_pkg::GROUP_RESET;
      link_slave_address_reg <= trip_setpoint_pkg::SLAVE_RESET;
      link_baud_select_reg <= trip_setpoint_pkg::BAUD_RESET[1:0];
      link_parity_select_reg <= trip_setpoint_pkg::PARITY_RESET[1:0];
      link_stop_bits_reg <= trip_setpoint_pkg::STOP_RESET[0];
    end else if (wr_ok) begin
      case (sel)
        trip_setpoint_pkg::SEL_PASSWORD: password_reg <= req_wdata;
        trip_setpoint_pkg::SEL_GROUP: group_reg <= req_wdata;
        trip_setpoint_pkg::SEL_SLAVE: link_slave_address_reg <= req_wdata;
        trip_setpoint_pkg::SEL_BAUD: link_baud_select_reg <= req_wdata[1:0];
        trip_setpoint_pkg::SEL_PARITY: begin
          link_parity_select_reg <= req_wdata[1:0];
        end
        trip_setpoint_pkg::SEL_STOP: link_stop_bits_reg <= req_wdata[0];
        default: password_reg <= password_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection setpoints.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ground_fault_pickup_reg <= trip_setpoint_pkg::PICKUP_RESET;
      ground_fault_delay_reg <= trip_setpoint_pkg::DELAY_RESET;
      thermal_memory_en_reg <= trip_setpoint_pkg::THERMAL_RESET[0];
      neutral_phase_ratio_reg <= trip_setpoint_pkg::NEUTRAL_RESET;
      second_load_alarm_reg <= trip_setpoint_pkg::ALARM2_RESET;
      prealarm_setting_reg <= trip_setpoint_pkg::PREALARM_RESET;
    end else begin
      // A dial between detents reads as an illegal code and is ignored.
      if (fixed_reg && dial_pickup_ok) begin
        ground_fault_pickup_reg <= dial_pickup_code;
      end
      if (fixed_reg && dial_delay_ok) begin
        ground_fault_delay_reg <= dial_delay_code;
      end
      if (wr_ok) begin
        case (sel)
          trip_setpoint_pkg::SEL_PICKUP: begin
            ground_fault_pickup_reg <= req_wdata;
          end
          trip_setpoint_pkg::SEL_DELAY: begin
            ground_fault_delay_reg <= req_wdata;
          end
          trip_setpoint_pkg::SEL_THERMAL: begin
            thermal_memory_en_reg <= req_wdata[0];
          end
          trip_setpoint_pkg::SEL_NEUTRAL: begin
            neutral_phase_ratio_reg <= req_wdata;
          end
          trip_setpoint_pkg::SEL_ALARM2: begin
            second_load_alarm_reg <= req_wdata;
          end
          trip_setpoint_pkg::SEL_PREALARM: begin
            prealarm_setting_reg <= req_wdata;
          end
          default: prealarm_setting_reg <= prealarm_setting_reg;
        endcase
      end
    end
  end

  // The warning level reaches protection only in trip mode; zero disarms it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ground_fault_warning_level_reg <= 16'h0000;
    end else if (gf_mode == trip_setpoint_pkg::GF_MODE_TRIP) begin
      ground_fault_warning_level_reg <= prealarm_setting_reg;
    end else begin
      ground_fault_warning_level_reg <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer path.
  always_comb begin
    rdata_next = 16'h0000;
    case (sel)
      trip_setpoint_pkg::SEL_PASSWORD: rdata_next = 16'h0000;
      trip_setpoint_pkg::SEL_GROUP: rdata_next = group_reg;
      trip_setpoint_pkg::SEL_SLAVE: rdata_next = link_slave_address_reg;
      trip_setpoint_pkg::SEL_BAUD: rdata_next = 16'(link_baud_select_reg);
      trip_setpoint_pkg::SEL_PARITY: rdata_next = 16'(link_parity_select_reg);
      trip_setpoint_pkg::SEL_STOP: rdata_next = 16'(link_stop_bits_reg);
      trip_setpoint_pkg::SEL_PICKUP: rdata_next = ground_fault_pickup_reg;
      trip_setpoint_pkg::SEL_DELAY: rdata_next = ground_fault_delay_reg;
      trip_setpoint_pkg::SEL_THERMAL: rdata_next = 16'(thermal_memory_en_reg);
      trip_setpoint_pkg::SEL_NEUTRAL: rdata_next = neutral_phase_ratio_reg;
      trip_setpoint_pkg::SEL_ALARM2: rdata_next = second_load_alarm_reg;
      trip_setpoint_pkg::SEL_PREALARM: rdata_next = prealarm_setting_reg;
      default: rdata_next = 16'h0000;
    endcase
  end

  always_comb begin
    if (sel == trip_setpoint_pkg::SEL_NONE) begin
      status_next = trip_setpoint_pkg::RSP_BAD_ADDR;
    end else if (req_write && !(writable && value_ok)) begin
      status_next = trip_setpoint_pkg::RSP_BAD_VALUE;
    end else begin
      status_next = trip_setpoint_pkg::RSP_OK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_status <= trip_setpoint_pkg::RSP_OK;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_status <= status_next;
        rsp_rdata <= req_write ? 16'h0000 : rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_pickup_range;
    !fixed_reg |-> ground_fault_pickup_reg >= trip_setpoint_pkg::PICKUP_MIN &&
                   ground_fault_pickup_reg <= trip_setpoint_pkg::PICKUP_MAX;
  endproperty
  a_pickup_range: assert property (p_pickup_range)
    else $error("pickup left its range");

  property p_fixed_pickup_ro;
    req_valid && req_write && fixed_reg &&
    req_addr == trip_setpoint_pkg::GROUND_FAULT_PICKUP_OFS
    |=> rsp_valid && rsp_status == trip_setpoint_pkg::RSP_BAD_VALUE;
  endproperty
  a_fixed_pickup_ro: assert property (p_fixed_pickup_ro)
    else $error("fixed pickup accepted a write");

  property p_delay_range;
    ground_fault_delay_reg <= trip_setpoint_pkg::DELAY_MAX;
  endproperty
  a_delay_range: assert property (p_delay_range)
    else $error("delay left its range");

  property p_neutral_set;
    neutral_phase_ratio_reg == 16'h0000 ||
    neutral_phase_ratio_reg == trip_setpoint_pkg::NEUTRAL_LOW ||
    neutral_phase_ratio_reg == trip_setpoint_pkg::NEUTRAL_FULL;
  endproperty
  a_neutral_set: assert property (p_neutral_set)
    else $error("neutral ratio not a legal percentage");

  property p_alarm2_range;
    second_load_alarm_reg >= trip_setpoint_pkg::ALARM2_MIN &&
    second_load_alarm_reg <= trip_setpoint_pkg::ALARM2_MAX;
  endproperty
  a_alarm2_range: assert property (p_alarm2_range)
    else $error("second load alarm out of range");

  property p_warning_gate;
    gf_mode != trip_setpoint_pkg::GF_MODE_TRIP
    |=> ground_fault_warning_level_reg == 16'h0000;
  endproperty
  a_warning_gate: assert property (p_warning_gate)
    else $error("warning level armed outside trip mode");

  property p_link_page;
    req_valid && req_addr == trip_setpoint_pkg::LINK_BAUD_SELECT_OFS &&
    group_reg != trip_setpoint_pkg::GROUP_LINK_CODE
    |=> rsp_status == trip_setpoint_pkg::RSP_BAD_ADDR &&
        $stable(link_baud_select_reg);
  endproperty
  a_link_page: assert property (p_link_page)
    else $error("link page reachable without selector");

  property p_slave_range;
    link_slave_address_reg >= trip_setpoint_pkg::SLAVE_MIN &&
    link_slave_address_reg <= trip_setpoint_pkg::SLAVE_MAX;
  endproperty
  a_slave_range: assert property (p_slave_range)
    else $error("slave address out of range");

  property p_reject_keeps;
    req_valid && req_write && sel == trip_setpoint_pkg::SEL_PREALARM &&
    !value_ok |=> $stable(prealarm_setting_reg) &&
                  rsp_status == trip_setpoint_pkg::RSP_BAD_VALUE;
  endproperty
  a_reject_keeps: assert property (p_reject_keeps)
    else $error("rejected write changed the pre-alarm");

  property p_password_hidden;
    req_valid && !req_write && sel == trip_setpoint_pkg::SEL_PASSWORD
    |=> rsp_rdata == 16'h0000;
  endproperty
  a_password_hidden: assert property (p_password_hidden)
    else $error("password readable");

  c_link_write: cover property (wr_ok && sel == trip_setpoint_pkg::SEL_BAUD);
  c_refused: cover property (rsp_status == trip_setpoint_pkg::RSP_BAD_VALUE);
  c_thermal_off: cover property (!thermal_memory_en_reg);

endmodule : trip_unit_setpoint_registers

/* File: src/trip_setpoint_pkg.sv */
// Constants shared by the setpoint register bank and its code checker.
// Assumes word addresses are Modbus holding register numbers in hex.
package trip_setpoint_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register numbers.
  localparam logic [19:0] ACCESS_PASSWORD_OFS = 20'h62638;
  localparam logic [19:0] SETTINGS_GROUP_SELECTOR_OFS = 20'h62639;
  localparam logic [19:0] LINK_SLAVE_ADDRESS_OFS = 20'h6263a;
  localparam logic [19:0] LINK_BAUD_SELECT_OFS = 20'h6263b;
  localparam logic [19:0] LINK_PARITY_SELECT_OFS = 20'h6263c;
  localparam logic [19:0] LINK_STOP_BITS_OFS = 20'h6263d;
  localparam logic [19:0] GROUND_FAULT_PICKUP_OFS = 20'h6264b;
  localparam logic [19:0] GROUND_FAULT_DELAY_OFS = 20'h6264c;
  localparam logic [19:0] GROUND_FAULT_THERMAL_MEMORY_OFS = 20'h6264d;
  localparam logic [19:0] NEUTRAL_PROTECTION_RATIO_OFS = 20'h6264e;
  localparam logic [19:0] SECOND_LOAD_ALARM_LEVEL_OFS = 20'h6264f;
  localparam logic [19:0] GROUND_FAULT_PREALARM_OFS = 20'h62650;

  ////////////////////////////////////////////////////////////////////////////
  // Register selects after address decode.
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_PASSWORD = 4'h1;
  localparam logic [3:0] SEL_GROUP = 4'h2;
  localparam logic [3:0] SEL_SLAVE = 4'h3;
  localparam logic [3:0] SEL_BAUD = 4'h4;
  localparam logic [3:0] SEL_PARITY = 4'h5;
  localparam logic [3:0] SEL_STOP = 4'h6;
  localparam logic [3:0] SEL_PICKUP = 4'h7;
  localparam logic [3:0] SEL_DELAY = 4'h8;
  localparam logic [3:0] SEL_THERMAL = 4'h9;
  localparam logic [3:0] SEL_NEUTRAL = 4'ha;
  localparam logic [3:0] SEL_ALARM2 = 4'hb;
  localparam logic [3:0] SEL_PREALARM = 4'hc;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [15:0] PASSWORD_RESET = 16'h0000;
  localparam logic [15:0] GROUP_RESET = 16'h0000;
  localparam logic [15:0] SLAVE_RESET = 16'h0002;
  localparam logic [15:0] BAUD_RESET = 16'h0001;
  localparam logic [15:0] PARITY_RESET = 16'h0002;
  localparam logic [15:0] STOP_RESET = 16'h0001;
  localparam logic [15:0] PICKUP_RESET = 16'h0064;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [15:0] THERMAL_RESET = 16'h0001;
  localparam logic [15:0] NEUTRAL_RESET = 16'h0064;
  localparam logic [15:0] ALARM2_RESET = 16'h0064;
  localparam logic [15:0] PREALARM_RESET = 16'h0032;

  ////////////////////////////////////////////////////////////////////////////
  // Code limits and fixed codes.
  localparam logic [15:0] GROUP_LINK_CODE = 16'h02ff;
  localparam logic [15:0] PICKUP_MIN = 16'h0014;
  localparam logic [15:0] PICKUP_MAX = 16'h0064;
  localparam logic [15:0] DELAY_MAX = 16'h0064;
  localparam logic [15:0] THERMAL_MAX = 16'h0001;
  localparam logic [15:0] NEUTRAL_LOW = 16'h003c;
  localparam logic [15:0] NEUTRAL_FULL = 16'h0064;
  localparam logic [15:0] ALARM2_MIN = 16'h0032;
  localparam logic [15:0] ALARM2_MAX = 16'h0078;
  localparam logic [15:0] PREALARM_MIN = 16'h0032;
  localparam logic [15:0] PREALARM_MAX = 16'h0064;
  localparam logic [15:0] PREALARM_STEP = 16'h0005;
  localparam logic [15:0] SLAVE_MIN = 16'h0001;
  localparam logic [15:0] SLAVE_MAX = 16'h00f7;
  localparam logic [15:0] BAUD_MAX = 16'h0003;
  localparam logic [15:0] PARITY_MAX = 16'h0002;
  localparam logic [15:0] STOP_MAX = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Answer status and ground-fault modes.
  localparam logic [1:0] RSP_OK = 2'h0;
  localparam logic [1:0] RSP_BAD_ADDR = 2'h1;
  localparam logic [1:0] RSP_BAD_VALUE = 2'h2;
  localparam logic [1:0] GF_MODE_TRIP = 2'h0;
  localparam logic [1:0] GF_MODE_ALARM = 2'h1;
  localparam logic [1:0] GF_MODE_OFF = 2'h2;

endpackage : trip_setpoint_pkg

/* File: src/setpoint_code_check.sv */
// Combinational legality check of one code for one setpoint register.
// Assumes sel comes from the register bank's address decode or is tied to a dial's select.
`timescale 1ns/1ns
module setpoint_code_check (
  // Code under test.
  input wire logic [3:0] sel,
  input wire logic [15:0] code,
  input wire logic fixed,
  // Verdict.
  output logic ok
);

  always_comb begin
    ok = 1'b0;
    case (sel)
      trip_setpoint_pkg::SEL_PASSWORD: ok = 1'b1;
      trip_setpoint_pkg::SEL_GROUP: ok = 1'b1;
      trip_setpoint_pkg::SEL_SLAVE: begin
        ok = code >= trip_setpoint_pkg::SLAVE_MIN &&
             code <= trip_setpoint_pkg::SLAVE_MAX;
      end
      trip_setpoint_pkg::SEL_BAUD: begin
        ok = code <= trip_setpoint_pkg::BAUD_MAX;
      end
      trip_setpoint_pkg::SEL_PARITY: begin
        ok = code <= trip_setpoint_pkg::PARITY_MAX;
      end
      trip_setpoint_pkg::SEL_STOP: begin
        ok = code <= trip_setpoint_pkg::STOP_MAX;
      end
      trip_setpoint_pkg::SEL_PICKUP: begin
        if (fixed) begin
          ok = code == 16'h0014 || code == 16'h001e || code == 16'h0028 ||
               code == 16'h003c || code == 16'h0050 ||
               code == 16'h0064;
        end else begin
          ok = code >= trip_setpoint_pkg::PICKUP_MIN &&
               code <= trip_setpoint_pkg::PICKUP_MAX;
        end
      end
      trip_setpoint_pkg::SEL_DELAY: begin
        if (fixed) begin
          ok = code == 16'h0000 || code == 16'h0002 || code == 16'h000a ||
               code == 16'h001e || code == 16'h0032 || code == 16'h004b ||
               code == 16'h0064;
        end else begin
          ok = code <= trip_setpoint_pkg::DELAY_MAX;
        end
      end
      trip_setpoint_pkg::SEL_THERMAL: begin
        ok = code <= trip_setpoint_pkg::THERMAL_MAX;
      end
      trip_setpoint_pkg::SEL_NEUTRAL: begin
        ok = code == 16'h0000 || code == trip_setpoint_pkg::NEUTRAL_LOW ||
             code == trip_setpoint_pkg::NEUTRAL_FULL;
      end
      trip_setpoint_pkg::SEL_ALARM2: begin
        ok = code >= trip_setpoint_pkg::ALARM2_MIN &&
             code <= trip_setpoint_pkg::ALARM2_MAX;
      end
      trip_setpoint_pkg::SEL_PREALARM: begin
        ok = code >= trip_setpoint_pkg::PREALARM_MIN &&
             code <= trip_setpoint_pkg::PREALARM_MAX &&
             (code % trip_setpoint_pkg::PREALARM_STEP) == 16'h0000;
      end
      default: ok = 1'b0;
    endcase
  end

endmodule : setpoint_code_check

/* File: tb/link_master_model.sv */
// Far-side serial link master, issuing single-word requests.
// Assumes the bench calls its tasks; lines change at falling mclk.
`timescale 1ns/1ns
module link_master_model (
  // Clock.
  input wire logic mclk,
  // Word request.
  output logic req_valid,
  output logic req_write,
  output logic [19:0] req_addr,
  output logic [15:0] req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 20'h0;
    req_wdata = 16'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Back-to-back calls keep the strobe high, one request per cycle.
  task automatic xfer(input logic w, input logic [19:0] a,
                      input logic [15:0] d);
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
  endtask : xfer
  // Released lines flip on each call, so a second idle in a row restores the last request's write, address and data with the strobe still low.
  task automatic idle();
    @(negedge mclk);
    req_valid = 1'b0;
    req_write = ~req_write;
    req_addr = ~req_addr;
    req_wdata = ~req_wdata;
  endtask : idle
endmodule : link_master_model

/* File: tb/trip_unit_setpoint_registers_tb.sv */
// Self-checking bench of the setpoint register bank.
// Assumes the master model drives requests; answers are queued and compared.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end
module trip_unit_setpoint_registers_tb;
  logic mclk, rst_n, fixed_variant, req_valid, req_write, rsp_valid;
  logic [15:0] dial_pickup_code, dial_delay_code, req_wdata, rsp_rdata;
  logic [1:0] gf_mode, rsp_status, baud, parity;
  logic [19:0] req_addr;
  logic [15:0] pickup, delay, neutral, alarm2, warn, slave, sh [0:24];
  logic thermal, stop;
  logic [18:0] e, expq [$];
  int n_fail = 0, tests_run = 0, seed = 93;
  trip_unit_setpoint_registers u_dut (.mclk(mclk), .rst_n(rst_n),
    .fixed_variant(fixed_variant), .dial_pickup_code(dial_pickup_code),
    .dial_delay_code(dial_delay_code), .gf_mode(gf_mode),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
    .rsp_rdata(rsp_rdata), .ground_fault_pickup_reg(pickup),
    .ground_fault_delay_reg(delay), .thermal_memory_en_reg(thermal),
    .neutral_phase_ratio_reg(neutral), .second_load_alarm_reg(alarm2),
    .ground_fault_warning_level_reg(warn), .link_slave_address_reg(slave),
    .link_baud_select_reg(baud), .link_parity_select_reg(parity),
    .link_stop_bits_reg(stop));
  link_master_model u_master (.mclk(mclk), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (expq.size() != 0) n_fail++;
    $display("Comparisons %0d, errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // Index i is the word number above the password word.
  task automatic rd(input logic [4:0] i);
    u_master.xfer(1'b0, trip_setpoint_pkg::ACCESS_PASSWORD_OFS + 20'(i),
                  16'h0000);
    expq.push_back({1'b1, trip_setpoint_pkg::RSP_OK, sh[i]});
  endtask : rd
  // The password word never reads back, so its shadow stays zero.
  task automatic wr(input logic [4:0] i, input logic [15:0] d, input bit ok);
    u_master.xfer(1'b1, trip_setpoint_pkg::ACCESS_PASSWORD_OFS + 20'(i), d);
    expq.push_back({1'b1, ok ? trip_setpoint_pkg::RSP_OK :
      trip_setpoint_pkg::RSP_BAD_VALUE, 16'h0});
    if (ok && i != 5'h0) sh[i] = d;
    rd(i);
  endtask : wr
  task automatic bad(input logic [19:0] a);
    u_master.xfer(1'b0, a, 16'h0);
    expq.push_back({1'b0, trip_setpoint_pkg::RSP_BAD_ADDR, 16'h0});
  endtask : bad
  task automatic do_reset();
    u_master.idle();
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    sh = '{2: 16'h2, 3: 16'h1, 4: 16'h2, 5: 16'h1, 19: 16'h64, 21: 16'h1,
      22: 16'h64, 23: 16'h64, 24: 16'h32, default: 16'h0};
  endtask : do_reset
  //////////////////////////////////////////////////////////////////////////
  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 19'h7ffff;
      `CHK(rsp_status, e[17:16])
      if (e[18]) `CHK(rsp_rdata, e[15:0])
    end
  end
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {rst_n, fixed_variant, gf_mode} = 4'h0;
    dial_pickup_code = 16'h3c;
    dial_delay_code = 16'h4b;
    do_reset();
    for (int i = 19; i < 25; i++) rd(5'(i));
    rd(5'h0);
    bad(20'h6263a);
    wr(5'h1, 16'h02ff, 1);
    for (int i = 2; i < 6; i++) rd(5'(i));
    wr(5'h0, 16'($random(seed)), 1);
    wr(5'h13, 16'h13, 0);
    wr(5'h13, 16'h14, 1);
    wr(5'h13, 16'h65, 0);
    wr(5'h14, 16'h65, 0);
    wr(5'h14, 16'h64, 1);
    wr(5'h15, 16'h2, 0);
    wr(5'h15, 16'h0, 1);
    wr(5'h15, 16'h1, 1);
    wr(5'h16, 16'h32, 0);
    wr(5'h16, 16'h0, 1);
    wr(5'h16, 16'h3c, 1);
    wr(5'h17, 16'h79, 0);
    wr(5'h17, 16'h31, 0);
    wr(5'h17, 16'h32 + 16'(($random(seed) & 32'hff) % 71), 1);
    wr(5'h18, 16'h34, 0);
    wr(5'h18, 16'h69, 0);
    wr(5'h18, 16'h37, 1);
    wr(5'h2, 16'h0, 0);
    wr(5'h2, 16'hf8, 0);
    wr(5'h2, 16'hf7, 1);
    for (int j = 0; j < 5; j++) wr(5'h3, 16'(j), j < 4);
    for (int j = 0; j < 4; j++) wr(5'h4, 16'(j), j < 3);
    for (int j = 0; j < 3; j++) wr(5'h5, 16'(j), j < 2);
    bad(20'h62640);
    u_master.idle();
    `CHK({baud, parity, stop, thermal}, 6'h3b)
    `CHK({neutral, slave}, 32'h003c00f7)
    `CHK({pickup, delay, alarm2}, {sh[19], sh[20], sh[23]})
    for (int k = 0; k < 4; k++) begin
      gf_mode = (k < 3) ? 2'(k) : 2'(($random(seed) & 32'hff) % 3);
      repeat (2) @(negedge mclk);
      `CHK(warn, (gf_mode == 2'h0) ? sh[24] : 16'h0)
    end
    fixed_variant = 1'b1;
    do_reset();
    sh[19] = 16'h3c;
    sh[20] = 16'h4b;
    rd(5'h13);
    wr(5'h14, 16'h0, 0);
    wr(5'h13, 16'h14, 0);
    bad(20'h6264f);
    bad(20'h6263b);
    u_master.idle();
    `CHK({pickup, delay}, 32'h003c004b)
    dial_pickup_code = 16'h32;
    dial_delay_code = 16'h2;
    repeat (2) @(negedge mclk);
    `CHK({pickup, delay}, 32'h003c0002)
    repeat (3) @(negedge mclk);
    end_of_test();
  end
endmodule : trip_unit_setpoint_registers_tb
